// >>> design/sas_sequencer.sv
// SAR converter sequencer: APB registers, pacer, rotation and sample queue
//
// Register access over APB and the register offsets were decided locally.
`default_nettype none
module sas_sequencer
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analogue converter side
    output logic             sarStart,
    output logic      [2:0]  sarChannel,
    input  wire sas_sample_t sarSample,
    // System requests
    output logic             sampleRequest,
    output logic             irq
);
    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic       apbAcc;
    logic       wrEn;
    logic       rdEn;
    logic       selCtrl;
    logic       selResult;
    logic       selQcs;
    logic       selQdata;
    logic       selDiv;
    logic       selIrqEn;
    logic       selIrqSt;
    logic       mapped;
    logic       ctrlWr;
    logic       qcsWr;
    logic       divWr;
    logic       irqEnWr;
    logic       onceWr;
    logic       popReq;

    // Zero-wait slave: every access completes in its first access cycle
    assign apbAcc    = psel & penable;
    assign wrEn      = apbAcc & pwrite;
    assign rdEn      = apbAcc & ~pwrite;
    assign selCtrl   = (paddr == OFS_CTRL);
    assign selResult = (paddr == OFS_RESULT);
    assign selQcs    = (paddr == OFS_QCS);
    assign selQdata  = (paddr == OFS_QDATA);
    assign selDiv    = (paddr == OFS_DIV);
    assign selIrqEn  = (paddr == OFS_IRQEN);
    assign selIrqSt  = (paddr == OFS_IRQST);
    assign mapped    = selCtrl | selResult | selQcs | selQdata | selDiv | selIrqEn | selIrqSt;
    assign ctrlWr    = wrEn & selCtrl;
    assign qcsWr     = wrEn & selQcs;
    assign divWr     = wrEn & selDiv;
    assign irqEnWr   = wrEn & selIrqEn;
    assign onceWr    = ctrlWr & pwdata[CTRL_ONCE];
    assign pready    = 1'b1;
    assign pslverr   = apbAcc & ~mapped;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic        many_q;
    logic [2:0]  inputSel_q;
    logic [4:0]  mask_q;
    logic        busy_q;
    logic [6:0]  cnt_q;
    logic        startPulse_q;
    logic [2:0]  chan_q;
    logic [11:0] result_q;
    logic        errLast_q;
    logic        capEn_q;
    logic        narrow_q;
    logic        errTag_q;
    logic        dreqEn_q;
    logic        over_q;
    logic [3:0]  thresh_q;
    logic [15:0] whole_q;
    logic [7:0]  frac_q;
    logic [16:0] paceCnt_q;
    logic [7:0]  acc_q;
    logic        irqEn_q;
    logic [2:0]  wrPtr_q;
    logic [2:0]  rdPtr_q;
    logic [3:0]  level_q;
    sas_sample_t mem [8];

    // ------------------------------------------------------------------
    // Channel rotation
    // ------------------------------------------------------------------
    // Next code after cur whose mask bit is set; scanning downward lets the
    // nearest candidate win. Out-of-range codes wrap into the five inputs.
    function automatic logic [2:0] rotNext(input logic [2:0] cur, input logic [4:0] mask);
        logic [2:0] pick;
        logic [2:0] cand;
        pick = cur;
        cand = cur;
        for (int i = NUM_INPUTS; i >= 1; i--)
        begin
            cand = 3'((int'(cur) + i) % NUM_INPUTS);
            if (mask[cand])
                pick = cand;
        end
        return pick;
    endfunction

    logic       doneNow;
    logic       rotEn;
    logic [2:0] rotSel;
    logic [2:0] startSel;
    logic [2:0] inputSel_d;

    assign doneNow  = busy_q & (cnt_q == CONV_LAST);
    assign rotEn    = many_q & (mask_q != 5'h00);
    assign rotSel   = rotNext(inputSel_q, mask_q);
    // A write in the start cycle is seen by that conversion, no settling
    assign startSel = ctrlWr ? pwdata[CTRL_SEL+:3] :
                      (doneNow & rotEn) ? rotSel : inputSel_q;
    assign inputSel_d = startSel;

    // ------------------------------------------------------------------
    // Pacer
    // ------------------------------------------------------------------
    logic [8:0]  paceSum;
    logic        divZero;
    logic        paceFire;
    logic        paceLoad;
    logic [15:0] whole_d;
    logic [7:0]  frac_d;
    logic [16:0] paceCnt_d;
    logic [7:0]  acc_d;

    assign whole_d   = divWr ? pwdata[DIV_WHOLE+:16] : whole_q;
    assign frac_d    = divWr ? pwdata[DIV_FRAC+:8] : frac_q;
    assign divZero   = (whole_q == 16'h0000) & (frac_q == 8'h00);
    assign paceSum   = {1'b0, acc_q} + {1'b0, frac_q};
    assign paceFire  = many_q & ~divZero & (paceCnt_q == 17'h00000);
    // Writing the divider or stopping restarts the interval from scratch
    assign paceLoad  = ~many_q | divWr;
    assign paceCnt_d = paceLoad ? {1'b0, whole_d} :
                       paceFire ? ({1'b0, whole_q} + {16'h0000, paceSum[8]}) :
                       (paceCnt_q - 17'h00001);
    assign acc_d     = paceLoad ? 8'h00 : paceFire ? paceSum[7:0] : acc_q;

    // ------------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------------
    logic       startEvt;
    logic       busy_d;
    logic [6:0] cnt_d;

    // Pacer fires while busy are dropped; divider zero restarts on completion
    assign startEvt = onceWr |
                      (many_q & (divZero ? (~busy_q | doneNow) : (paceFire & ~busy_q)));
    assign busy_d   = startEvt | (busy_q & ~doneNow);
    assign cnt_d    = startEvt ? 7'h00 : busy_q ? (cnt_q + 7'h01) : cnt_q;

    // Converter sequencing registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            busy_q       <= 1'b0;
            cnt_q        <= 7'h00;
            startPulse_q <= 1'b0;
            chan_q       <= RST_SEL;
            inputSel_q   <= RST_SEL;
        end
        else
        begin
            busy_q       <= busy_d;
            cnt_q        <= cnt_d;
            startPulse_q <= startEvt;
            chan_q       <= startEvt ? startSel : chan_q;
            inputSel_q   <= inputSel_d;
        end
    end

    // Result and error of the latest conversion
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            result_q  <= 12'h000;
            errLast_q <= 1'b0;
        end
        else if (doneNow)
        begin
            result_q  <= sarSample.value;
            errLast_q <= sarSample.err;
        end
    end

    // Pacer registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            paceCnt_q <= {1'b0, RST_WHOLE};
            acc_q     <= 8'h00;
        end
        else
        begin
            paceCnt_q <= paceCnt_d;
            acc_q     <= acc_d;
        end
    end

    // Software configuration
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            many_q   <= 1'b0;
            mask_q   <= RST_MASK;
            capEn_q  <= 1'b0;
            narrow_q <= 1'b0;
            errTag_q <= 1'b0;
            dreqEn_q <= 1'b0;
            thresh_q <= RST_THRESH;
            whole_q  <= RST_WHOLE;
            frac_q   <= RST_FRAC;
            irqEn_q  <= 1'b0;
        end
        else
        begin
            if (ctrlWr)
            begin
                many_q <= pwdata[CTRL_MANY];
                mask_q <= pwdata[CTRL_MASK+:5];
            end
            if (qcsWr)
            begin
                capEn_q  <= pwdata[QCS_EN];
                narrow_q <= pwdata[QCS_NARROW];
                errTag_q <= pwdata[QCS_ERRTAG];
                dreqEn_q <= pwdata[QCS_DREQ];
                thresh_q <= pwdata[QCS_THRESH+:4];
            end
            whole_q <= whole_d;
            frac_q  <= frac_d;
            if (irqEnWr)
                irqEn_q <= pwdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Sample queue
    // ------------------------------------------------------------------
    logic        qEmpty;
    logic        qFull;
    logic        pushReq;
    logic        pushOk;
    logic        overSet;
    sas_sample_t pushEntry;
    sas_sample_t headEntry;
    logic [3:0]  level_d;

    assign qEmpty   = (level_q == 4'h0);
    assign qFull    = (level_q == QUEUE_DEPTH);
    assign pushReq  = doneNow & capEn_q;
    assign pushOk   = pushReq & ~qFull;
    assign overSet  = pushReq & qFull;
    assign popReq   = rdEn & selQdata & ~qEmpty;
    assign pushEntry.value = narrow_q ? {4'h0, sarSample.value[11:4]} : sarSample.value;
    assign pushEntry.err   = errTag_q & sarSample.err;
    assign headEntry = mem[rdPtr_q];
    assign level_d  = level_q + {3'h0, pushOk} - {3'h0, popReq};

    // Storage holds no control state, so it is left out of reset
    always_ff @(posedge clock)
    begin
        if (pushOk)
            mem[wrPtr_q] <= pushEntry;
    end

    // Queue pointers, level and sticky overflow; a new overflow beats a clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wrPtr_q <= 3'h0;
            rdPtr_q <= 3'h0;
            level_q <= 4'h0;
            over_q  <= 1'b0;
        end
        else
        begin
            wrPtr_q <= wrPtr_q + {2'h0, pushOk};
            rdPtr_q <= rdPtr_q + {2'h0, popReq};
            level_q <= level_d;
            over_q  <= overSet | (over_q & ~(qcsWr & pwdata[QCS_OVER]));
        end
    end

    // ------------------------------------------------------------------
    // Requests and read-back
    // ------------------------------------------------------------------
    logic        levelMet;
    logic        irqStatus;
    logic [31:0] ctrlRd;
    logic [31:0] qcsRd;
    logic [31:0] qdataRd;

    // Level-driven: clears when the queue drains below threshold, the threshold is raised or the enable is cleared
    assign levelMet      = (level_q >= thresh_q);
    assign sampleRequest = dreqEn_q & levelMet;
    assign irqStatus     = irqEn_q & levelMet;
    assign irq           = irqStatus;
    assign sarStart      = startPulse_q;
    assign sarChannel    = chan_q;
    // Register images for read-back
    always_comb
    begin
        ctrlRd                  = 32'h00000000;
        ctrlRd[CTRL_MANY]       = many_q;
        ctrlRd[CTRL_READY]      = ~busy_q;
        ctrlRd[CTRL_ERR]        = errLast_q;
        ctrlRd[CTRL_SEL+:3]     = inputSel_q;
        ctrlRd[CTRL_MASK+:5]    = mask_q;
        qcsRd                   = 32'h00000000;
        qcsRd[QCS_EN]           = capEn_q;
        qcsRd[QCS_NARROW]       = narrow_q;
        qcsRd[QCS_ERRTAG]       = errTag_q;
        qcsRd[QCS_DREQ]         = dreqEn_q;
        qcsRd[QCS_EMPTY]        = qEmpty;
        qcsRd[QCS_FULL]         = qFull;
        qcsRd[QCS_OVER]         = over_q;
        qcsRd[QCS_LEVEL+:4]     = level_q;
        qcsRd[QCS_THRESH+:4]    = thresh_q;
        qdataRd                 = 32'h00000000;
        qdataRd[11:0]           = qEmpty ? 12'h000 : headEntry.value;
        qdataRd[QDATA_ERR]      = ~qEmpty & headEntry.err;
    end
    // Read data mux; unmapped offsets read zero with an error
    assign prdata = ~rdEn ? 32'h00000000 :
                    selCtrl   ? ctrlRd :
                    selResult ? {20'h00000, result_q} :
                    selQcs    ? qcsRd :
                    selQdata  ? qdataRd :
                    selDiv    ? {8'h00, whole_q, frac_q} :
                    selIrqEn  ? {31'h00000000, irqEn_q} :
                    selIrqSt  ? {31'h00000000, irqStatus} : 32'h00000000;
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [7:0] sinceStart_q;
    // Cycles since the latest start, saturating; read only by checks
    always_ff @(posedge clock)
    begin
        if (rst)
            sinceStart_q <= 8'hff;
        else if (startEvt)
            sinceStart_q <= 8'h00;
        else if (sinceStart_q != 8'hff)
            sinceStart_q <= sinceStart_q + 8'h01;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_START_READY: assert property (onceWr |=> busy_q && cnt_q == 7'h00 && sarStart)
        else $error("one-shot write did not start a conversion");
    AST_CONV_LEN: assert property (doneNow |-> sinceStart_q == 8'd95)
        else $error("conversion length is not 96 cycles");
    AST_RESULT: assert property (doneNow |=> result_q == $past(sarSample.value))
        else $error("result register missed the conversion value");
    AST_SEL_APPLIED: assert property (ctrlWr && onceWr |=> sarChannel == $past(pwdata[14:12]))
        else $error("new input selection not used by following start");
    AST_BACK2BACK: assert property (doneNow && many_q && divZero |=> busy_q && cnt_q == 7'h00)
        else $error("free-running conversion did not restart at once");
    AST_PACE_IGNORED: assert property (paceFire && busy_q && !onceWr |=> !sarStart)
        else $error("pacer fire during conversion was not ignored");
    AST_ROTATE: assert property (doneNow && rotEn && !ctrlWr |=> mask_q[inputSel_q])
        else $error("rotation picked a channel outside the mask");
    AST_NO_ROTATE: assert property (doneNow && mask_q == 5'h00 && !ctrlWr |=> $stable(inputSel_q))
        else $error("input select moved with empty rotation mask");
    AST_OVERFLOW: assert property (overSet && !popReq |=> over_q && level_q == QUEUE_DEPTH)
        else $error("full-queue completion did not set overflow cleanly");
    AST_NARROW: assert property (pushOk && narrow_q |=> mem[$past(wrPtr_q)].value[11:8] == 4'h0)
        else $error("narrowed entry has upper bits set");
    AST_POP: assert property (popReq && !pushOk |=> level_q == $past(level_q) - 4'h1)
        else $error("queue data read did not remove one entry");
    AST_IRQ_DRAIN: assert property (irq && !popReq && !qcsWr && !irqEnWr |=> irq)
        else $error("interrupt dropped without a queue drain");
    AST_CAPTURE_RESET: assert property (disable iff (1'b0) rst |=> !capEn_q)
        else $error("capture enable not cleared by reset");
    COV_ONESHOT: cover property (onceWr ##1 busy_q [*3] ##[90:100] doneNow);
    COV_ROTATE: cover property (doneNow && rotEn ##1 inputSel_q != $past(inputSel_q));
    COV_OVERFLOW: cover property (overSet);
    COV_DREQ: cover property ($rose(sampleRequest) ##[1:1000] $fell(sampleRequest));
endmodule
`default_nettype wire

// >>> inc/sas_pkg.sv
// Constants, register layout and carrier types of the SAR converter sequencer
// Behaviour
// - Writing one to the start bit begins a conversion at once; ready drops.
// - A conversion lasts 96 clock cycles, then ready returns high.
// - Each finished conversion stores its 12-bit value in the result register.
// - Input select codes 0 to 3 pick external inputs, 4 the temperature sensor.
// - A new input selection applies, without delay, to conversions started after it.
// - With continuous trigger set, conversions start repeatedly without software.
// - With divider zero, each free-running conversion starts when the previous ends.
// - Whole divider n fires every n+1 cycles; fires during a conversion are ignored.
// - Nonzero fraction dithers intervals between whole+1 and whole+2 cycles.
// - With continuous trigger set and a nonzero rotation mask, input select advances to next enabled code.
// - An all-zero rotation mask leaves input select unchanged between conversions.
// - The first rotating sample uses the current selection even if masked off.
// - With capture enabled, each finished conversion is pushed into an 8-entry queue.
// - Completion into a full queue sets sticky overflow and drops the sample.
// - With narrowing set, queued entries hold conversion bits 11:4 in bits 7:0.
// - With error tagging set, each queue entry carries the failed-conversion flag.
// - Queue capture enable is cleared by reset.
// - DMA request is high when enabled and queue level reaches the threshold.
// - Interrupt is high when level reaches threshold, gated by the enable mask.
// - The interrupt clears by draining the queue below the threshold, raising the threshold or clearing its enable.
`default_nettype none
package sas_pkg;
    // ------------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------------
    localparam int unsigned CONV_CYCLES = 96;
    localparam logic [6:0]  CONV_LAST   = 7'(CONV_CYCLES - 1);
    localparam logic [3:0]  QUEUE_DEPTH = 4'h8;
    localparam int unsigned NUM_INPUTS  = 5;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_RESULT = 12'h004;
    localparam logic [11:0] OFS_QCS    = 12'h008;
    localparam logic [11:0] OFS_QDATA  = 12'h00c;
    localparam logic [11:0] OFS_DIV    = 12'h010;
    localparam logic [11:0] OFS_IRQEN  = 12'h014;
    localparam logic [11:0] OFS_IRQST  = 12'h018;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ONCE   = 0;
    localparam int CTRL_MANY   = 1;
    localparam int CTRL_READY  = 8;
    localparam int CTRL_ERR    = 9;
    localparam int CTRL_SEL    = 12;
    localparam int CTRL_MASK   = 16;
    localparam int QCS_EN      = 0;
    localparam int QCS_NARROW  = 1;
    localparam int QCS_ERRTAG  = 2;
    localparam int QCS_DREQ    = 3;
    localparam int QCS_EMPTY   = 8;
    localparam int QCS_FULL    = 9;
    localparam int QCS_OVER    = 10;
    localparam int QCS_LEVEL   = 16;
    localparam int QCS_THRESH  = 24;
    localparam int QDATA_ERR   = 15;
    localparam int DIV_FRAC    = 0;
    localparam int DIV_WHOLE   = 8;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  RST_SEL    = 3'h0;
    localparam logic [4:0]  RST_MASK   = 5'h00;
    localparam logic [3:0]  RST_THRESH = 4'h0;
    localparam logic [15:0] RST_WHOLE  = 16'h0000;
    localparam logic [7:0]  RST_FRAC   = 8'h00;
    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        err;
        logic [11:0] value;
    } sas_sample_t;
endpackage
`default_nettype wire

// >>> sim/sas_sar_model.sv
// Behavioural model of the analogue converter answering start pulses
`default_nettype none
module sas_sar_model
    import sas_pkg::*;
(
    // Clock
    input  wire logic       clock,
    // Converter handshake
    input  wire logic       sarStart,
    input  wire logic [2:0] sarChannel,
    output var sas_sample_t sarSample
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Sample source
    // --------------------------------------------------------------
    // Code depends on the channel so a wrong mux choice shows up;
    // the temperature input reports a failed convergence
    always @(posedge clock)
    begin
        if (sarStart)
        begin
            sarSample.value <= {sarChannel, 9'h0a5};
            sarSample.err   <= (sarChannel == 3'h4);
        end
    end
endmodule
`default_nettype wire

// >>> sim/sas_sequencer_tb.sv
// Self-checking bench of the converter sequencer over APB
`default_nettype none
module sas_sequencer_tb
    import sas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Signals, instances and tasks
    // --------------------------------------------------------------
    logic        clock, rst, psel, penable, pwrite, pready, pslverr;
    logic        sarStart, sampleRequest, irq, errSeen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  sarChannel, ch;
    sas_sample_t sarSample;
    int          n_errors, n_tests, gap, i;
    sas_sequencer sas_sequencer_inst (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sarStart(sarStart),
        .sarChannel(sarChannel), .sarSample(sarSample),
        .sampleRequest(sampleRequest), .irq(irq));
    sas_sar_model sas_sar_model_inst (.clock(clock), .sarStart(sarStart),
        .sarChannel(sarChannel), .sarSample(sarSample));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Setup then access; held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd      = prdata;
        errSeen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // Adds the edges up to the next start pulse to gap; back-to-back calls
    // therefore cover consecutive intervals with none skipped
    task automatic measure();
        do
        begin
            @(posedge clock);
            gap++;
        end while (sarStart !== 1'b1);
    endtask
    task automatic print_verdict();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Whole run needs about 3350 cycles
    initial
    begin
        repeat (12000) @(posedge clock);
        n_errors++;
        print_verdict();
    end
    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial
    begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
        n_errors = 0;
        n_tests  = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rdchk(OFS_QCS, 32'h100);
        // One-shot on every input code; ready low through cycle 96
        for (i = 0; i < 5; i++)
        begin
            apb(1'b1, OFS_CTRL, (i << CTRL_SEL) | 1);
            rdchk(OFS_CTRL, i << CTRL_SEL);
            repeat (90) @(posedge clock);
            rdchk(OFS_CTRL, i << CTRL_SEL);
            rdchk(OFS_CTRL, (i << CTRL_SEL) | 32'h100 | (i == 4 ? 32'h200 : 0));
            rdchk(OFS_RESULT, {i[2:0], 9'h0a5});
        end
        // Rotation into the queue; request enabled before streaming starts
        apb(1'b1, OFS_DIV, 32'h0);
        apb(1'b1, OFS_IRQEN, 32'h1);
        apb(1'b1, OFS_QCS, 32'h0100000d);
        apb(1'b1, OFS_CTRL, 32'h00140002);
        repeat (500) @(posedge clock);
        check(irq, 1);
        check(sampleRequest, 1);
        rdchk(OFS_IRQST, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
        do apb(1'b0, OFS_CTRL, 32'h0); while (rd[CTRL_READY] !== 1'b1);
        rdchk(OFS_QCS, 32'h0106000d);
        for (i = 0; i < 6; i++)
        begin
            ch = (i == 0) ? 3'h0 : ((i % 2) ? 3'h2 : 3'h4);
            rdchk(OFS_QDATA, {16'h0, ch == 3'h4, 3'h0, ch, 9'h0a5});
        end
        @(posedge clock);
        check(irq, 0);
        check(sampleRequest, 0);
        // Overflow with narrowing and rotation off
        apb(1'b1, OFS_QCS, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h3002);
        repeat (1000) @(posedge clock);
        apb(1'b1, OFS_CTRL, 32'h3000);
        do apb(1'b0, OFS_CTRL, 32'h0); while (rd[CTRL_READY] !== 1'b1);
        rdchk(OFS_QCS, 32'h00080603);
        for (i = 0; i < 8; i++)
            rdchk(OFS_QDATA, 32'h6a);
        rdchk(OFS_QCS, 32'h00000503);
        // Pacer: whole, dithered fraction, then back to back
        apb(1'b1, OFS_DIV, 32'(199) << DIV_WHOLE);
        apb(1'b1, OFS_CTRL, 32'h2);
        measure();
        gap = 0;
        measure();
        check(32'(gap), 32'd200);
        apb(1'b1, OFS_DIV, 32'h6380);
        measure();
        gap = 0;
        measure();
        measure();
        check(32'(gap), 32'd201);
        // Pacer faster than a conversion drops every other fire; then divider zero runs back to back
        apb(1'b1, OFS_DIV, 32'(49) << DIV_WHOLE);
        measure();
        gap = 0;
        measure();
        check(32'(gap), 32'd100);
        apb(1'b1, OFS_DIV, 32'h0);
        measure();
        gap = 0;
        measure();
        check(32'(gap), 32'd96);
        // Unmapped address is refused
        apb(1'b0, 12'hffc, 32'h0);
        check(errSeen, 1);
        check(rd, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
